//--- rtl/sfm_top.sv
`timescale 1ns/1ps
`default_nettype none
module sfm_top #(
	parameter int P_TICK_CYC = sfm_pkg::TICK_CYC,
	parameter int P_DI_N = 4,
	parameter int P_DO_N = 2
)(
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	input wire logic I_KEY_UP,
	input wire logic I_KEY_DOWN,
	input wire logic [P_DI_N-1:0] I_DI,
	output logic [P_DO_N-1:0] O_DO,
	input wire logic I_ALARM_EVT,
	input wire logic [15:0] I_ALARM_CODE,
	input wire logic I_ALARM_CLASS,
	input wire logic I_ALARM_RESETTABLE,
	input wire logic I_ALARM_WARN,
	input wire logic I_CAUSE_PRESENT,
	input wire logic [15:0] I_MOTOR_SPEED,
	input wire logic [15:0] I_SPEED_CMD,
	input wire logic [15:0] I_PULSE_SPEED,
	input wire logic [31:0] I_POS_DEV,
	input wire logic [15:0] I_BUS_VOLT,
	input wire logic [15:0] I_CURRENT_RMS,
	input wire logic [15:0] I_LOAD_FACTOR,
	input wire logic [15:0] I_INERTIA,
	input wire logic [15:0] I_ENC_ERRS,
	input wire logic [31:0] I_IN_SIGS,
	input wire logic [31:0] I_OUT_SIGS,
	output logic O_STOP_REQ,
	output logic [1:0] O_STOP_METHOD,
	output logic O_TORQUE_MODE,
	output logic [15:0] O_TORQUE_CMD,
	output logic [15:0] O_SPEED_LIMIT
);
	import sfm_pkg::*;

	function automatic logic [7:0] fn_at(input logic [31:0] v, input int i);
		return v[8*i +: 8];
	endfunction

	function automatic logic [31:0] sx16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	// ************************
	// Pin synchronisers
	// ************************
	logic [P_DI_N+1:0] pin_lvl;
	logic keys_both_q;
	sfm_sync3 #(.W(P_DI_N + 2)) u_sync (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.i_async({I_KEY_UP, I_KEY_DOWN, I_DI}),
		.o_level(pin_lvl)
	);
	wire [P_DI_N-1:0] di_lvl = pin_lvl[P_DI_N-1:0];
	wire keys_both = pin_lvl[P_DI_N+1] & pin_lvl[P_DI_N];
	// Holding both keys gives one request, not a stream
	wire key_clr = keys_both & ~keys_both_q;

	// ************************
	// Register bus decode
	// ************************
	logic [3:0] stop_cfg_q;
	logic [3:0] cmode_q;
	logic [7:0] tsrc_q;
	logic [15:0] tpre_q [4];
	logic [15:0] slim_q;
	logic [8*P_DI_N-1:0] di_fn_q;
	logic [8*P_DO_N-1:0] do_fn_q;
	logic aux_clr_q;
	wire wr_ctrl = I_WR && I_ADDR == ADDR_CTRL;
	wire wr_stop = I_WR && I_ADDR == ADDR_STOP;
	wire wr_cmode = I_WR && I_ADDR == ADDR_CMODE;
	wire wr_tsrc = I_WR && I_ADDR == ADDR_TSRC;
	wire wr_slim = I_WR && I_ADDR == ADDR_SLIM;
	wire wr_difn = I_WR && I_ADDR == ADDR_DIFN;
	wire wr_dofn = I_WR && I_ADDR == ADDR_DOFN;
	wire wr_tpre = I_WR && I_ADDR[7:4] == ADDR_TPRE0[7:4];
	wire [1:0] tpre_idx = I_ADDR[3:2];

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			stop_cfg_q <= STOP_RST;
			cmode_q <= CMODE_RST;
			tsrc_q <= TSRC_RST;
			slim_q <= SLIM_RST;
			di_fn_q <= '0;
			do_fn_q <= '0;
			aux_clr_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				tpre_q[i] <= 16'h0000;
			end
		end else begin
			aux_clr_q <= wr_ctrl & I_WDATA[CTRL_CLR_BIT];
			if (wr_stop) stop_cfg_q <= I_WDATA[3:0];
			if (wr_cmode) cmode_q <= I_WDATA[3:0];
			if (wr_tsrc) tsrc_q <= I_WDATA[7:0];
			if (wr_slim) slim_q <= I_WDATA[15:0];
			if (wr_difn) di_fn_q <= I_WDATA[8*P_DI_N-1:0];
			if (wr_dofn) do_fn_q <= I_WDATA[8*P_DO_N-1:0];
			if (wr_tpre) tpre_q[tpre_idx] <= I_WDATA[15:0];
		end
	end

	// ************************
	// Input functions
	// ************************
	logic [P_DI_N-1:0] di_is_clr;
	logic [P_DI_N-1:0] di_is_ta;
	logic [P_DI_N-1:0] di_is_tb;
	for (genvar g = 0; g < P_DI_N; g++) begin : g_di
		assign di_is_clr[g] = fn_at(32'(di_fn_q), g) == FN_ALM_CLR;
		assign di_is_ta[g] = fn_at(32'(di_fn_q), g) == FN_TOR_A;
		assign di_is_tb[g] = fn_at(32'(di_fn_q), g) == FN_TOR_B;
	end
	// Level input: clears for as long as it is held active
	wire di_clr = |(di_is_clr & di_lvl);
	wire tor_a = |(di_is_ta & di_lvl);
	wire tor_b = |(di_is_tb & di_lvl);

	// ************************
	// Fault and warning latch
	// ************************
	logic [3:0] flt_q;
	logic warn_q;
	logic [15:0] cur_code_q;
	wire clr_req = key_clr | aux_clr_q | di_clr;
	// Reset only takes while the cause is gone
	wire clr_ok = clr_req & ~I_CAUSE_PRESENT;
	wire evt_flt = I_ALARM_EVT & ~I_ALARM_WARN;
	wire evt_warn = I_ALARM_EVT & I_ALARM_WARN;
	wire [1:0] evt_idx = {I_ALARM_CLASS, ~I_ALARM_RESETTABLE};
	wire [3:0] flt_set = evt_flt ? 4'h1 << evt_idx : 4'h0;
	// Non-resettable bits survive any clear; only I_RSTN drops them
	wire [3:0] flt_keep = clr_ok ? flt_q & FLT_NR_MASK : flt_q;
	// New event wins over a clear in the same cycle
	wire [3:0] flt_d = flt_keep | flt_set;
	wire warn_d = (warn_q & ~clr_ok) | evt_warn;
	wire flt_any = |flt_q;
	wire c1_act = |flt_q[1:0];

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			flt_q <= 4'h0;
			warn_q <= 1'b0;
			cur_code_q <= 16'h0000;
			keys_both_q <= 1'b0;
		end else begin
			flt_q <= flt_d;
			warn_q <= warn_d;
			keys_both_q <= keys_both;
			if (I_ALARM_EVT) begin
				cur_code_q <= I_ALARM_CODE;
			end else if (flt_d == 4'h0 && !warn_d) begin
				cur_code_q <= 16'h0000;
			end
		end
	end

	// ************************
	// Timestamp, 0.1 s units
	// ************************
	logic [31:0] cyc_q;
	logic [31:0] time_q;
	wire tick = cyc_q == 32'(P_TICK_CYC - 1);
	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cyc_q <= 32'h0;
			time_q <= 32'h0;
		end else begin
			cyc_q <= tick ? 32'h0 : cyc_q + 32'h1;
			if (tick) time_q <= time_q + 32'h1;
		end
	end

	// ************************
	// History and snapshot
	// ************************
	logic [15:0] hcode_q [HIST_N];
	logic [31:0] htime_q [HIST_N];
	logic hvalid_q;
	logic [31:0] snap_q [SNAP_N];
	logic [31:0] snap_d [SNAP_N];
	wire [31:0] age = time_q - htime_q[0];
	wire repeat_hit = hvalid_q && I_ALARM_CODE == hcode_q[0]
		&& age < REPEAT_TICKS;
	wire log_en = I_ALARM_EVT && !repeat_hit;
	assign snap_d[0] = {16'h0, I_ALARM_CODE};
	assign snap_d[1] = time_q;
	assign snap_d[2] = sx16(I_MOTOR_SPEED);
	assign snap_d[3] = sx16(I_SPEED_CMD);
	assign snap_d[4] = sx16(O_TORQUE_CMD);
	assign snap_d[5] = sx16(I_PULSE_SPEED);
	assign snap_d[6] = I_POS_DEV;
	assign snap_d[7] = {16'h0, I_BUS_VOLT};
	assign snap_d[8] = sx16(I_CURRENT_RMS);
	assign snap_d[9] = {16'h0, I_LOAD_FACTOR};
	assign snap_d[10] = {16'h0, I_INERTIA};
	assign snap_d[11] = {16'h0, I_ENC_ERRS};
	assign snap_d[12] = I_IN_SIGS;
	assign snap_d[13] = I_OUT_SIGS;

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			hvalid_q <= 1'b0;
			for (int i = 0; i < HIST_N; i++) begin
				hcode_q[i] <= 16'h0;
				htime_q[i] <= 32'h0;
			end
			for (int i = 0; i < SNAP_N; i++) begin
				snap_q[i] <= 32'h0;
			end
		end else begin
			if (log_en) begin
				hvalid_q <= 1'b1;
				// Newest at index 0, oldest falls off the end
				hcode_q[0] <= I_ALARM_CODE;
				htime_q[0] <= time_q;
				for (int i = 1; i < HIST_N; i++) begin
					hcode_q[i] <= hcode_q[i-1];
					htime_q[i] <= htime_q[i-1];
				end
			end
			if (I_ALARM_EVT) begin
				for (int i = 0; i < SNAP_N; i++) begin
					snap_q[i] <= snap_d[i];
				end
			end
		end
	end

	// ************************
	// Torque command and limits
	// ************************
	wire tmode = cmode_q == MODE_TORQUE;
	wire [3:0] tsrc_x = tsrc_q[TSRC_X_LSB +: 4];
	wire [3:0] tsrc_y = tsrc_q[TSRC_Y_LSB +: 4];
	// Mixed selection takes priority over the single preset
	wire [15:0] tsel = tsrc_y == TSRC_Y_MIX ? tpre_q[{tor_b, tor_a}]
		: tsrc_x == TSRC_X_DIG ? tpre_q[0] : 16'h0000;
	wire [15:0] slim_sel = tsrc_y == TSRC_Y_SLIM ? slim_q : SLIM_FREE;
	wire [1:0] stop_sel = c1_act ? stop_cfg_q[STOP_C1_LSB +: 2]
		: stop_cfg_q[STOP_C2_LSB +: 2];
	logic [P_DO_N-1:0] do_d;
	for (genvar g = 0; g < P_DO_N; g++) begin : g_do
		assign do_d[g] = (fn_at(32'(do_fn_q), g) == FN_WARN_OUT && warn_q)
			|| (fn_at(32'(do_fn_q), g) == FN_FLT_OUT && flt_any);
	end

	// ************************
	// Read mux and outputs
	// ************************
	wire [1:0] rgn = I_ADDR[7:6];
	wire [3:0] ridx = I_ADDR[5:2];
	logic [31:0] low_d;
	logic [31:0] rd_d;
	always_comb begin
		low_d = 32'h0;
		case (I_ADDR)
			ADDR_STOP: low_d = {28'h0, stop_cfg_q};
			ADDR_CMODE: low_d = {28'h0, cmode_q};
			ADDR_TSRC: low_d = {24'h0, tsrc_q};
			ADDR_SLIM: low_d = {16'h0, slim_q};
			ADDR_DIFN: low_d = 32'(di_fn_q);
			ADDR_DOFN: low_d = 32'(do_fn_q);
			ADDR_STAT: low_d = {cur_code_q, 9'h0, stop_sel, warn_q, flt_q};
			ADDR_TIME: low_d = time_q;
			default: if (wr_tpre | I_ADDR[7:4] == ADDR_TPRE0[7:4]) begin
				low_d = sx16(tpre_q[tpre_idx]);
			end
		endcase
	end
	always_comb begin
		rd_d = 32'h0;
		if (I_ADDR[1:0] == 2'h0) begin
			case (rgn)
				RGN_LOW: rd_d = low_d;
				RGN_HCODE: if (ridx < 4'(HIST_N)) rd_d = {16'h0, hcode_q[ridx]};
				RGN_HTIME: if (ridx < 4'(HIST_N)) rd_d = htime_q[ridx];
				default: if (ridx < 4'(SNAP_N)) rd_d = snap_q[ridx];
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RDATA <= 32'h0;
			O_DO <= '0;
			O_STOP_REQ <= 1'b0;
			O_STOP_METHOD <= STOP_COAST;
			O_TORQUE_MODE <= 1'b0;
			O_TORQUE_CMD <= 16'h0;
			O_SPEED_LIMIT <= SLIM_FREE;
		end else begin
			O_RDATA <= I_RD ? rd_d : 32'h0;
			O_DO <= do_d;
			O_STOP_REQ <= flt_any;
			O_STOP_METHOD <= stop_sel;
			O_TORQUE_MODE <= tmode;
			O_TORQUE_CMD <= tmode ? tsel : 16'h0000;
			O_SPEED_LIMIT <= slim_sel;
		end
	end

	// ************************
	// Assertions
	// ************************
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RSTN);
	property p_c1_stop;
		c1_act |=> O_STOP_REQ && O_STOP_METHOD == $past(stop_cfg_q[1:0]);
	endproperty
	a_c1_stop: assert property (p_c1_stop) else $error("stop one");
	property p_c2_stop;
		!c1_act && flt_q[3:2] != 2'h0 |=> O_STOP_METHOD == $past(stop_cfg_q[3:2]);
	endproperty
	a_c2_stop: assert property (p_c2_stop) else $error("stop two");
	property p_nr_stays;
		flt_q[1] |=> flt_q[1];
	endproperty
	a_nr_stays: assert property (p_nr_stays) else $error("nr lost");
	property p_key_clr;
		key_clr && !I_CAUSE_PRESENT && !I_ALARM_EVT |=> !flt_q[0] && !flt_q[2];
	endproperty
	a_key_clr: assert property (p_key_clr) else $error("key reset");
	property p_di_clr;
		di_clr && !I_CAUSE_PRESENT && !I_ALARM_EVT |=> !warn_q;
	endproperty
	a_di_clr: assert property (p_di_clr) else $error("input clear");
	// Warning slot is the last output, fault slot the first
	property p_warn_do;
		fn_at(32'(do_fn_q), P_DO_N - 1) == FN_WARN_OUT
			|=> O_DO[P_DO_N-1] == $past(warn_q);
	endproperty
	a_warn_do: assert property (p_warn_do) else $error("warning out");
	property p_flt_do;
		fn_at(32'(do_fn_q), 0) == FN_FLT_OUT |=> O_DO[0] == $past(flt_any);
	endproperty
	a_flt_do: assert property (p_flt_do) else $error("fault out");
	property p_no_torque;
		!tmode |=> O_TORQUE_CMD == 16'h0 && !O_TORQUE_MODE;
	endproperty
	a_no_torque: assert property (p_no_torque) else $error("torque");
	property p_zero_lim;
		tsrc_y == TSRC_Y_SLIM && slim_q == 16'h0 |=> O_SPEED_LIMIT == 16'h0;
	endproperty
	a_zero_lim: assert property (p_zero_lim) else $error("speed limit");
	property p_repeat;
		I_ALARM_EVT && repeat_hit |=> hcode_q[1] == $past(hcode_q[1]);
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat logged");
	property p_order;
		log_en |=> hcode_q[1] == $past(hcode_q[0])
			&& hcode_q[0] == $past(I_ALARM_CODE);
	endproperty
	a_order: assert property (p_order) else $error("history order");
	property p_latch;
		flt_any && !clr_ok |=> flt_any ##1 O_STOP_REQ;
	endproperty
	a_latch: assert property (p_latch) else $error("fault dropped");
	c_clear: cover property (flt_q[0] ##1 !flt_q[0]);
	c_repeat: cover property (I_ALARM_EVT && repeat_hit);
	c_mix: cover property (tmode && tsrc_y == TSRC_Y_MIX && tor_a && tor_b);
endmodule
`default_nettype wire

//--- inc/sfm_pkg.sv
package sfm_pkg;
	// ************************
	// Timing
	// ************************
	localparam int CLK_NS = 50;
	localparam int TICK_NS = 100_000_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int REPEAT_S = 30;
	localparam int TICKS_PER_S = 10;
	localparam logic [31:0] REPEAT_TICKS = 32'(REPEAT_S * TICKS_PER_S);
	localparam int HIST_N = 10;
	localparam int SNAP_N = 14;
	// ************************
	// Register offsets
	// ************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STOP = 8'h04;
	localparam logic [7:0] ADDR_CMODE = 8'h08;
	localparam logic [7:0] ADDR_TSRC = 8'h0C;
	localparam logic [7:0] ADDR_TPRE0 = 8'h10;
	localparam logic [7:0] ADDR_SLIM = 8'h20;
	localparam logic [7:0] ADDR_DIFN = 8'h24;
	localparam logic [7:0] ADDR_DOFN = 8'h28;
	localparam logic [7:0] ADDR_STAT = 8'h2C;
	localparam logic [7:0] ADDR_TIME = 8'h30;
	localparam logic [1:0] RGN_LOW = 2'h0;
	localparam logic [1:0] RGN_HCODE = 2'h1;
	localparam logic [1:0] RGN_HTIME = 2'h2;
	localparam logic [1:0] RGN_SNAP = 2'h3;
	// ************************
	// Fields and reset values
	// ************************
	localparam int CTRL_CLR_BIT = 0;
	localparam int STOP_C1_LSB = 0;
	localparam int STOP_C2_LSB = 2;
	localparam int TSRC_X_LSB = 0;
	localparam int TSRC_Y_LSB = 4;
	localparam logic [1:0] STOP_COAST = 2'h0;
	localparam logic [1:0] STOP_ZSPD = 2'h1;
	localparam logic [3:0] STOP_RST = {STOP_ZSPD, STOP_COAST};
	localparam logic [3:0] CMODE_RST = 4'h0;
	localparam logic [7:0] TSRC_RST = 8'h00;
	localparam logic [15:0] SLIM_RST = 16'h0000;
	localparam logic [15:0] SLIM_FREE = 16'h7FFF;
	localparam logic [3:0] MODE_TORQUE = 4'h2;
	localparam logic [3:0] TSRC_X_DIG = 4'h0;
	localparam logic [3:0] TSRC_Y_SLIM = 4'h2;
	localparam logic [3:0] TSRC_Y_MIX = 4'h3;
	// Fault latch bit index is {class, non-resettable}
	localparam logic [3:0] FLT_NR_MASK = 4'hA;
	// ************************
	// Pin function numbers
	// ************************
	localparam logic [7:0] FN_ALM_CLR = 8'h04;
	localparam logic [7:0] FN_WARN_OUT = 8'h08;
	localparam logic [7:0] FN_FLT_OUT = 8'h0B;
	localparam logic [7:0] FN_TOR_A = 8'h0C;
	localparam logic [7:0] FN_TOR_B = 8'h0D;
endpackage

//--- rtl/sfm_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module sfm_sync3 #(
	parameter int W = 1
)(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);
	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;
	logic [W-1:0] agree;
	// Level moves only once second and third stage agree
	assign agree = ~(ff2_q ^ ff3_q);
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ff1_q <= '0;
			ff2_q <= '0;
			ff3_q <= '0;
			o_level <= '0;
		end else begin
			ff1_q <= i_async;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
			o_level <= (agree & ff2_q) | (~agree & o_level);
		end
	end
endmodule
`default_nettype wire

//--- dv/sfm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfm_far_model #(
	parameter int P_HOLD = 6
)(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_fire,
	input wire logic [15:0] i_code,
	input wire logic [2:0] i_flags,
	input wire logic i_press,
	output logic o_evt,
	output logic [15:0] o_code,
	output logic o_cls,
	output logic o_res,
	output logic o_warn,
	output logic o_key_up,
	output logic o_key_down
);
	logic evt_q;
	logic [18:0] ev_q;
	logic [7:0] hold_q;
	// ************************
	// Alarm source and panel keys
	// ************************
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			evt_q <= 1'b0;
			ev_q <= 19'h00000;
			hold_q <= 8'h00;
		end else begin
			evt_q <= i_fire;
			// Fields are junk outside the pulse: the last value and its inverse in turn
			if (i_fire) begin
				ev_q <= {i_flags, i_code};
			end else begin
				ev_q <= ~ev_q;
			end
			if (i_press) begin
				hold_q <= 8'(P_HOLD);
			end else if (hold_q != 8'h00) begin
				hold_q <= hold_q - 8'h01;
			end
		end
	end
	assign o_evt = evt_q;
	assign {o_warn, o_res, o_cls, o_code} = ev_q;
	// Second key lands a cycle late, as a real hand does
	assign o_key_up = (hold_q != 8'h00);
	assign o_key_down = (hold_q != 8'h00) && (hold_q != 8'(P_HOLD));
endmodule
`default_nettype wire

//--- dv/sfm_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module sfm_bench;
	import sfm_pkg::*;
	logic clk, rstn, wr, rd, fire, press, cause;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, v, t1;
	logic [3:0] di;
	logic [1:0] dout, smeth;
	logic [15:0] code, snap, a_code, tcmd, slim;
	logic [2:0] flags;
	logic evt, a_cls, a_res, a_warn, k_up, k_dn, stop_req, tmode;
	logic [15:0] exp_h [5] = '{16'h52, 16'h54, 16'h53, 16'h51, 16'h50};
	int n_fail = 0;
	int n_checks = 0;
	sfm_far_model u_far (.i_clk(clk), .i_rstn(rstn), .i_fire(fire),
		.i_code(code), .i_flags(flags), .i_press(press), .o_evt(evt),
		.o_code(a_code), .o_cls(a_cls), .o_res(a_res), .o_warn(a_warn),
		.o_key_up(k_up), .o_key_down(k_dn));
	sfm_top #(.P_TICK_CYC(4)) dut (.I_REF_CLK(clk), .I_RSTN(rstn),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .I_KEY_UP(k_up), .I_KEY_DOWN(k_dn), .I_DI(di),
		.O_DO(dout), .I_ALARM_EVT(evt), .I_ALARM_CODE(a_code),
		.I_ALARM_CLASS(a_cls), .I_ALARM_RESETTABLE(a_res),
		.I_ALARM_WARN(a_warn), .I_CAUSE_PRESENT(cause),
		.I_MOTOR_SPEED(snap), .I_SPEED_CMD(snap), .I_PULSE_SPEED(snap),
		.I_POS_DEV({snap, snap}), .I_BUS_VOLT(snap + 16'h0001),
		.I_CURRENT_RMS(snap), .I_LOAD_FACTOR(snap), .I_INERTIA(snap),
		.I_ENC_ERRS(snap), .I_IN_SIGS({snap, snap}),
		.I_OUT_SIGS({snap, snap}), .O_STOP_REQ(stop_req),
		.O_STOP_METHOD(smeth), .O_TORQUE_MODE(tmode),
		.O_TORQUE_CMD(tcmd), .O_SPEED_LIMIT(slim));
	// ************************
	// Bus and event tasks
	// ************************
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		// Hand back on a rising edge so callers drive on it
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rreg(a, v);
		`CHK($sformatf("reg %h", a), e, v)
	endtask
	task automatic raise(input logic [15:0] c, input logic [2:0] f);
		@(posedge clk);
		fire <= 1'b1;
		code <= c;
		flags <= f;
		@(posedge clk);
		fire <= 1'b0;
		snap <= c ^ 16'h5A5A;
		wt(5);
	endtask
	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Whole run is under two thousand cycles
	initial begin
		wt(20000);
		n_fail++;
		print_verdict();
	end
	// ************************
	// Test sequence
	// ************************
	initial begin
		{rstn, wr, rd, fire, press, cause} = 6'h00;
		{addr, wdata, di, code, flags} = '0;
		snap = 16'h5A5A;
		wt(8);
		rstn <= 1'b1;
		wt(1);
		rchk(ADDR_STOP, {28'h0, STOP_RST});
		rchk(8'h3C, 32'h0);
		`CHK("speed limit", 16'h7FFF, slim)
		wreg(ADDR_DIFN, 32'h0D0C0004);
		wreg(ADDR_DOFN, 32'h0000080B);
		raise(16'h0050, 3'b010);
		`CHK("stop", 1'b1, stop_req)
		`CHK("method", STOP_COAST, smeth)
		`CHK("fault out", 2'b01, dout)
		rreg(ADDR_STAT, v);
		`CHK("latch", 4'h1, v[3:0])
		rchk(8'hC0, 32'h0050);
		rchk(8'hC8, 32'h5A0A);
		rchk(8'hDC, 32'h5A0B);
		cause <= 1'b1;
		wreg(ADDR_CTRL, 32'h1);
		wt(3);
		`CHK("stop", 1'b1, stop_req)
		cause <= 1'b0;
		wreg(ADDR_CTRL, 32'h1);
		wt(3);
		`CHK("fault out", 2'b00, dout)
		raise(16'h0051, 3'b011);
		`CHK("method", STOP_ZSPD, smeth)
		rreg(ADDR_STAT, v);
		`CHK("latch", 4'h4, v[3:0])
		@(posedge clk);
		press <= 1'b1;
		@(posedge clk);
		press <= 1'b0;
		wt(12);
		`CHK("stop", 1'b0, stop_req)
		wreg(ADDR_STOP, 32'h0000000B);
		raise(16'h0053, 3'b011);
		`CHK("method", 2'h2, smeth)
		raise(16'h0054, 3'b010);
		`CHK("method", 2'h3, smeth)
		di <= 4'h1;
		wt(8);
		`CHK("stop", 1'b0, stop_req)
		di <= 4'h0;
		wt(8);
		raise(16'h0052, 3'b010);
		wt(20);
		`CHK("stop", 1'b1, stop_req)
		for (int i = 0; i < 5; i++) begin
			rchk(8'h40 + 8'(4 * i), {16'h0, exp_h[i]});
		end
		raise(16'h0052, 3'b010);
		rchk(8'h44, 32'h0054);
		wt(1300);
		raise(16'h0052, 3'b010);
		rchk(8'h44, 32'h0052);
		rreg(8'h84, t1);
		rreg(8'h80, v);
		`CHK("log age", 1'b1, (v - t1) >= REPEAT_TICKS)
		wreg(ADDR_CTRL, 32'h1);
		raise(16'h0900, 3'b110);
		`CHK("warn out", 2'b10, dout)
		`CHK("stop", 1'b0, stop_req)
		wreg(ADDR_CTRL, 32'h1);
		wt(3);
		`CHK("warn out", 2'b00, dout)
		wreg(ADDR_TPRE0, 32'h0000FFFB);
		wreg(ADDR_CMODE, 32'h1);
		wt(3);
		`CHK("torque", 16'h0000, tcmd)
		`CHK("torque mode", 1'b0, tmode)
		wreg(ADDR_CMODE, {28'h0, MODE_TORQUE});
		wt(3);
		`CHK("torque", 16'hFFFB, tcmd)
		`CHK("torque mode", 1'b1, tmode)
		for (int i = 1; i < 4; i++) begin
			wreg(ADDR_TPRE0 + 8'(4 * i), 32'h0100 + 32'(i));
		end
		wreg(ADDR_TSRC, 32'h30);
		for (int s = 0; s < 4; s++) begin
			di <= {2'(s), 2'b00};
			wt(8);
			`CHK("torque", (s == 0) ? 16'hFFFB : 16'h0100 + 16'(s), tcmd)
		end
		di <= 4'h0;
		wreg(ADDR_TSRC, 32'h20);
		wt(3);
		`CHK("speed limit", 16'h0000, slim)
		raise(16'h0020, 3'b000);
		rreg(ADDR_STAT, v);
		`CHK("latch", 4'h2, v[3:0])
		wreg(ADDR_CTRL, 32'h1);
		di <= 4'h1;
		wt(8);
		`CHK("stop", 1'b1, stop_req)
		di <= 4'h0;
		rstn <= 1'b0;
		wt(2);
		rstn <= 1'b1;
		wt(2);
		`CHK("stop", 1'b0, stop_req)
		rchk(8'h40, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
